/* File: pkg/sce_consts.svh */
// constants of the shift/compare execution unit: opcodes, cycle counts,
// register offsets, field positions and fill codes.
// assumes inclusion by bare name from design files.
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH

// opcodes (printed octal)
`define SCE_OP_BSH   6'h17
`define SCE_OP_DSR   6'h20
`define SCE_OP_DSL   6'h21
`define SCE_OP_CSR   6'h22
`define SCE_OP_CSL   6'h23
`define SCE_OP_ROT   6'h24
`define SCE_OP_CMPA  6'h2c
`define SCE_OP_CMPM  6'h2d

// execution time in clock cycles
`define SCE_CYC_BSH  4'h2
`define SCE_CYC_DSR  4'h4
`define SCE_CYC_DSL  4'h3
`define SCE_CYC_CSR  4'h4
`define SCE_CYC_CSL  4'h3
`define SCE_CYC_ROT  4'h2
`define SCE_CYC_CMP  4'h2
`define SCE_CYC_NOP  4'h1

// instruction word fields, bit k of the word sits at index k-1
`define SCE_I_FSEL   24
`define SCE_I_OP_HI  19
`define SCE_I_OP_LO  14
`define SCE_I_AR_HI  13
`define SCE_I_AR_LO  10
`define SCE_I_CNT_HI 9

// data word: sign in the top bit, 24 data bits
`define SCE_SIGN     24
`define SCE_DIG_W    4
`define SCE_CHR_W    6
`define SCE_DIG_1W   10'h006
`define SCE_CHR_1W   10'h004
`define SCE_ROT_MAX  10'h019
`define SCE_DFILL    4'h3
`define SCE_MULTI    4'hf

// register offsets (byte addresses)
`define SCE_ADR_AR8  5'h00
`define SCE_ADR_AR4  5'h04
`define SCE_ADR_AR2  5'h08
`define SCE_ADR_AR1  5'h0c
`define SCE_ADR_STAT 5'h10

// status bits
`define SCE_ST_BUSY  0
`define SCE_ST_ERR   1
`define SCE_ST_GT    2
`define SCE_ST_LT    3
`define SCE_ST_EQ    4

`endif

/* File: pkg/sce_pkg.sv */
// types shared by the shift/compare execution unit.
// assumes nothing of its surroundings.
package sce_pkg;

  typedef enum logic {
    SCE_IDLE,
    SCE_RUN
  } sce_state_t;

  typedef enum logic [3:0] {
    SCE_K_NOP,
    SCE_K_BSH,
    SCE_K_DSR,
    SCE_K_DSL,
    SCE_K_CSR,
    SCE_K_CSL,
    SCE_K_ROT,
    SCE_K_CMPA,
    SCE_K_CMPM
  } sce_kind_t;

endpackage

/* File: logic/sce_exec.sv */
// execution unit for binary subtract higher, shifts, rotate and compares,
// with four arithmetic registers and a classic wishbone register slave.
// assumes one clock, synchronous active-high reset, and a sequencer that
// hands over a resolved count/operands with a one-cycle start pulse.
`timescale 1ns/1ps
`include "sce_consts.svh"

module sce_exec
  import sce_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        start_i,
  input  wire logic [24:0] instr_i,
  input  wire logic [24:0] mem_hi_i,
  input  wire logic [24:0] mem_lo_i,
  input  wire logic [24:0] field_mask_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             ind_gt_o,
  output logic             ind_lt_o,
  output logic             ind_eq_o,
  output logic             proc_err_o
);

  // ==========================================================
  // helpers
  // ==========================================================
  // index of the highest designated register; index 0 is AR8
  function automatic logic [1:0] first_idx(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h3;
    if (m[3]) begin
      r = 2'h0;
    end else if (m[2]) begin
      r = 2'h1;
    end else if (m[1]) begin
      r = 2'h2;
    end
    return r;
  endfunction

  function automatic logic [3:0] cycles_of(input sce_kind_t k);
    logic [3:0] c;
    case (k)
      SCE_K_BSH:  c = `SCE_CYC_BSH;
      SCE_K_DSR:  c = `SCE_CYC_DSR;
      SCE_K_DSL:  c = `SCE_CYC_DSL;
      SCE_K_CSR:  c = `SCE_CYC_CSR;
      SCE_K_CSL:  c = `SCE_CYC_CSL;
      SCE_K_ROT:  c = `SCE_CYC_ROT;
      SCE_K_CMPA: c = `SCE_CYC_CMP;
      SCE_K_CMPM: c = `SCE_CYC_CMP;
      default:    c = `SCE_CYC_NOP;
    endcase
    return c;
  endfunction

  // unit-wise shift of a 48-bit operand; fill 0011 for digits, 0 for chars
  function automatic logic [47:0] ushift(input logic [47:0] x, input logic [9:0] n,
                                         input logic left, input logic chr);
    logic [47:0] y;
    y = x;
    for (int i = 0; i < 12; i++) begin
      if (10'(i) < n) begin
        if (chr && left) begin
          y = {y[41:0], 6'h00};
        end else if (chr) begin
          y = {6'h00, y[47:6]};
        end else if (left) begin
          y = {y[43:0], `SCE_DFILL};
        end else begin
          y = {`SCE_DFILL, y[47:4]};
        end
      end
    end
    return y;
  endfunction

  // sign-magnitude subtract a - b; sign 1 means negative
  function automatic logic [48:0] sm_sub(input logic sa, input logic [47:0] ma,
                                         input logic sb, input logic [47:0] mb);
    logic [48:0] r;
    if (sa != sb) begin
      r = {sa, ma + mb};
    end else if (ma >= mb) begin
      r = {sa, ma - mb};
    end else begin
      r = {~sa, mb - ma};
    end
    return r;
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  sce_state_t  state_reg;
  sce_kind_t   kind_reg;
  sce_kind_t   kind_w;
  logic [3:0]  cnt_reg;
  logic [24:0] ins_reg;
  logic [24:0] mhi_reg;
  logic [24:0] mlo_reg;
  logic [24:0] fm_reg;
  logic [24:0] ar_reg [4];
  logic        err_reg;
  logic        gt_reg;
  logic        lt_reg;
  logic        eq_reg;
  logic        done_reg;
  logic        perr_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;

  // ==========================================================
  // instruction decode
  // ==========================================================
  wire [5:0] opc_w = instr_i[`SCE_I_OP_HI:`SCE_I_OP_LO];
  assign kind_w = (opc_w == `SCE_OP_BSH)  ? SCE_K_BSH  :
                  (opc_w == `SCE_OP_DSR)  ? SCE_K_DSR  :
                  (opc_w == `SCE_OP_DSL)  ? SCE_K_DSL  :
                  (opc_w == `SCE_OP_CSR)  ? SCE_K_CSR  :
                  (opc_w == `SCE_OP_CSL)  ? SCE_K_CSL  :
                  (opc_w == `SCE_OP_ROT)  ? SCE_K_ROT  :
                  (opc_w == `SCE_OP_CMPA) ? SCE_K_CMPA :
                  (opc_w == `SCE_OP_CMPM) ? SCE_K_CMPM : SCE_K_NOP;

  wire [3:0] sel_w  = ins_reg[`SCE_I_AR_HI:`SCE_I_AR_LO];
  wire [9:0] cnt_w  = ins_reg[`SCE_I_CNT_HI:0];
  wire       fsel_w = ins_reg[`SCE_I_FSEL];
  wire       two_w  = (sel_w & (sel_w - 4'h1)) != 4'h0;
  wire [1:0] ia_w   = first_idx(sel_w);
  wire [3:0] rest_w = sel_w & ~(4'h8 >> ia_w);
  wire [1:0] ib_w   = first_idx(rest_w);
  wire       multi_w = sel_w == `SCE_MULTI;
  wire [24:0] rhi_w = ar_reg[ia_w];
  wire [24:0] rlo_w = ar_reg[ib_w];
  wire        fin_w = (state_reg == SCE_RUN) && (cnt_reg == 4'h0);

  // ==========================================================
  // shifts and rotate
  // ==========================================================
  wire chr_w  = (kind_reg == SCE_K_CSR) || (kind_reg == SCE_K_CSL);
  wire left_w = (kind_reg == SCE_K_DSL) || (kind_reg == SCE_K_CSL);
  // single word sits high; the low half supplies fill units
  wire [23:0]  pad_w  = chr_w ? 24'h000000 : {6{`SCE_DFILL}};
  wire [47:0]  sin_w  = two_w ? {rhi_w[23:0], rlo_w[23:0]} : {rhi_w[23:0], pad_w};
  wire [47:0]  sout_w = ushift(sin_w, cnt_w, left_w, chr_w);
  wire [9:0]   unit1_w = chr_w ? `SCE_CHR_1W : `SCE_DIG_1W;
  wire [9:0]   units_w = two_w ? 10'(unit1_w << 1) : unit1_w;
  wire         serr_w  = cnt_w > units_w;
  wire [9:0]   rsh_w   = cnt_w % `SCE_ROT_MAX;
  wire [49:0]  rdbl_w  = {rhi_w, rhi_w} >> rsh_w;
  wire         rerr_w  = cnt_w > `SCE_ROT_MAX;

  // ==========================================================
  // subtract higher
  // ==========================================================
  // multiword: 12 is the minuend, 3 takes the difference
  wire [47:0] bma_w = multi_w ? {ar_reg[0][23:0], ar_reg[1][23:0]} : {24'h0, rhi_w[23:0]};
  wire        bsa_w = multi_w ? ar_reg[1][`SCE_SIGN] : rhi_w[`SCE_SIGN];
  wire [47:0] bmb_w = multi_w ? {mhi_reg[23:0], mlo_reg[23:0]} : {24'h0, mlo_reg[23:0]};
  wire [48:0] bres_w = sm_sub(bsa_w, bma_w, mlo_reg[`SCE_SIGN], bmb_w);

  // ==========================================================
  // compares
  // ==========================================================
  wire [24:0] fmk_w = fsel_w ? fm_reg : 25'h1ffffff;
  wire [24:0] cah_w = (two_w ? rhi_w : 25'h0) & fmk_w;
  wire [24:0] cal_w = (two_w ? rlo_w : rhi_w) & fmk_w;
  wire [24:0] cbh_w = (two_w ? mhi_reg : 25'h0) & fmk_w;
  wire [24:0] cbl_w = mlo_reg & fmk_w;
  wire [47:0] cma_w = {cah_w[23:0], cal_w[23:0]};
  wire [47:0] cmb_w = {cbh_w[23:0], cbl_w[23:0]};
  wire        mgt_w = cma_w > cmb_w;
  wire        mlt_w = cma_w < cmb_w;
  wire        csa_w = cal_w[`SCE_SIGN];
  wire        csb_w = cbl_w[`SCE_SIGN];
  // differing signs decide alone, so +0 beats -0
  wire        agt_w = (csa_w != csb_w) ? ~csa_w : (csa_w ? mlt_w : mgt_w);
  wire        alt_w = (csa_w != csb_w) ? csa_w : (csa_w ? mgt_w : mlt_w);
  wire        cmag_w = kind_reg == SCE_K_CMPM;
  wire        cgt_w = cmag_w ? mgt_w : agt_w;
  wire        clt_w = cmag_w ? mlt_w : alt_w;
  wire        is_cmp_w = cmag_w || (kind_reg == SCE_K_CMPA);

  // ==========================================================
  // result write-back
  // ==========================================================
  logic [3:0]  ex_we;
  logic [24:0] ex_val [4];
  logic        ex_err;

  always_comb begin
    ex_we  = 4'h0;
    ex_err = 1'b0;
    for (int i = 0; i < 4; i++) begin
      ex_val[i] = ar_reg[i];
    end
    case (kind_reg)
      SCE_K_BSH: begin
        // source register never written
        if (multi_w) begin
          ex_we[2]  = 1'b1;
          ex_we[3]  = 1'b1;
          ex_val[2] = {bres_w[48], bres_w[47:24]};
          ex_val[3] = {bres_w[48], bres_w[23:0]};
        end else if (two_w) begin
          ex_we[ib_w]  = 1'b1;
          ex_val[ib_w] = {bres_w[48], bres_w[23:0]};
        end
      end
      SCE_K_DSR, SCE_K_DSL, SCE_K_CSR, SCE_K_CSL: begin
        ex_we[ia_w]  = 1'b1;
        ex_val[ia_w] = {rhi_w[`SCE_SIGN], sout_w[47:24]};
        if (two_w) begin
          ex_we[ib_w]  = 1'b1;
          ex_val[ib_w] = {rlo_w[`SCE_SIGN], sout_w[23:0]};
        end
        ex_err = serr_w;
      end
      SCE_K_ROT: begin
        ex_we[ia_w]  = 1'b1;
        ex_val[ia_w] = rdbl_w[24:0];
        ex_err       = rerr_w;
      end
      default: begin
        // compares and unknown codes write no register
        ex_err = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // sequencing
  // ==========================================================
  wire take_w = (state_reg == SCE_IDLE) && start_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SCE_IDLE;
      kind_reg  <= SCE_K_NOP;
      cnt_reg   <= 4'h0;
    end else if (take_w) begin
      state_reg <= SCE_RUN;
      kind_reg  <= kind_w;
      cnt_reg   <= cycles_of(kind_w) - 4'h1;
    end else if (fin_w) begin
      state_reg <= SCE_IDLE;
    end else if (state_reg == SCE_RUN) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // operands held for the whole instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ins_reg <= 25'h0;
      mhi_reg <= 25'h0;
      mlo_reg <= 25'h0;
      fm_reg  <= 25'h0;
    end else if (take_w) begin
      ins_reg <= instr_i;
      mhi_reg <= mem_hi_i;
      mlo_reg <= mem_lo_i;
      fm_reg  <= field_mask_i;
    end
  end

  // ==========================================================
  // indicators and error
  // ==========================================================
  wire take_cmp_w = take_w && ((kind_w == SCE_K_CMPA) || (kind_w == SCE_K_CMPM));
  wire fin_cmp_w  = fin_w && is_cmp_w;
  wire fin_err_w  = fin_w && ex_err;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gt_reg <= 1'b0;
      lt_reg <= 1'b0;
      eq_reg <= 1'b0;
    end else if (take_cmp_w) begin
      gt_reg <= 1'b0;
      lt_reg <= 1'b0;
      eq_reg <= 1'b0;
    end else if (fin_cmp_w) begin
      gt_reg <= cgt_w;
      lt_reg <= clt_w;
      eq_reg <= ~cgt_w & ~clt_w;
    end
  end

  // sticky error: a new error wins over a software clear
  wire err_clr_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_reg  <= 1'b0;
      perr_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      err_reg  <= fin_err_w | (err_reg & ~err_clr_w);
      perr_reg <= fin_err_w;
      done_reg <= fin_w;
    end
  end

  // ==========================================================
  // wishbone slave
  // ==========================================================
  wire        req_w   = wb_cyc_i && wb_stb_i && !ack_reg;
  wire        wr_w    = req_w && wb_we_i;
  wire [31:0] bmask_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        hit_ar_w = (wb_adr_i == `SCE_ADR_AR8) || (wb_adr_i == `SCE_ADR_AR4) ||
                         (wb_adr_i == `SCE_ADR_AR2) || (wb_adr_i == `SCE_ADR_AR1);
  wire [1:0]  widx_w  = wb_adr_i[3:2];
  wire [31:0] wold_w  = {7'h00, ar_reg[widx_w]};
  wire [31:0] wnew_w  = (wold_w & ~bmask_w) | (wb_dat_i & bmask_w);
  // arithmetic register writes are dropped while an instruction runs
  wire        wb_arw_w = wr_w && hit_ar_w && (state_reg == SCE_IDLE);
  wire        is_st_w  = wb_adr_i == `SCE_ADR_STAT;
  assign err_clr_w = wr_w && is_st_w && wb_sel_i[0] && wb_dat_i[`SCE_ST_ERR];
  wire [31:0] stat_w = {27'h0, eq_reg, lt_reg, gt_reg, err_reg, state_reg == SCE_RUN};
  wire [31:0] rd_w;
  assign rd_w = hit_ar_w ? wold_w :
                is_st_w  ? stat_w : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg  <= req_w;
      rdat_reg <= req_w ? rd_w : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i) begin
        ar_reg[i] <= 25'h0;
      end else if (fin_w && ex_we[i]) begin
        ar_reg[i] <= ex_val[i];
      end else if (wb_arw_w && (widx_w == 2'(i))) begin
        ar_reg[i] <= wnew_w[24:0];
      end
    end
  end

  assign wb_dat_o   = rdat_reg;
  assign wb_ack_o   = ack_reg;
  assign busy_o     = state_reg == SCE_RUN;
  assign done_o     = done_reg;
  assign ind_gt_o   = gt_reg;
  assign ind_lt_o   = lt_reg;
  assign ind_eq_o   = eq_reg;
  assign proc_err_o = perr_reg;

endmodule

/* File: verification/sce_exec_chk.sv */
// checker for the shift/compare unit: timing, indicators, error pulse.
// assumes the unit's own port names and the shared constants header.
`timescale 1ns/1ps
`include "sce_consts.svh"

module sce_exec_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        start_i,
  input wire logic [24:0] instr_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        ind_gt_o,
  input wire logic        ind_lt_o,
  input wire logic        ind_eq_o,
  input wire logic        proc_err_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // decode of a taken request
  wire logic       acc_w = start_i & ~busy_o;
  wire logic [5:0] op_w  = instr_i[19:14];
  wire logic [9:0] cnt_w = instr_i[9:0];
  wire logic [2:0] ind_w = {ind_gt_o, ind_lt_o, ind_eq_o};
  wire logic       one_w = $onehot(instr_i[13:10]);
  wire logic       dig_w = op_w == `SCE_OP_DSR || op_w == `SCE_OP_DSL;
  wire logic       cmp_w = op_w == `SCE_OP_CMPA || op_w == `SCE_OP_CMPM;
  // ==========================================
  // assertions
  chk_bsh_timing:
  assert property (acc_w && op_w == `SCE_OP_BSH |=> busy_o [*2] ##1 (done_o && !busy_o))
    else $error("subtract higher timing wrong");
  chk_dsr_timing:
  assert property (acc_w && op_w == `SCE_OP_DSR |=> busy_o [*4] ##1 (done_o && !busy_o))
    else $error("digit right shift timing wrong");
  chk_dsl_timing:
  assert property (acc_w && op_w == `SCE_OP_DSL |=> busy_o [*3] ##1 (done_o && !busy_o))
    else $error("digit left shift timing wrong");
  chk_csr_timing:
  assert property (acc_w && op_w == `SCE_OP_CSR |=> busy_o [*4] ##1 (done_o && !busy_o))
    else $error("char right shift timing wrong");
  chk_csl_timing:
  assert property (acc_w && op_w == `SCE_OP_CSL |=> busy_o [*3] ##1 (done_o && !busy_o))
    else $error("char left shift timing wrong");
  chk_cmp_indicators:
  assert property (acc_w && cmp_w |=> (ind_w == 3'h0) [*2] ##1 ($onehot(ind_w) && done_o))
    else $error("compare indicator sequence wrong");
  chk_shift_err:
  assert property (acc_w && dig_w && one_w && cnt_w > 10'h006 |-> ##[4:5] proc_err_o)
    else $error("oversize digit shift not flagged");
  chk_rot_err:
  assert property (acc_w && op_w == `SCE_OP_ROT && cnt_w > 10'h019 |-> ##3 (proc_err_o && done_o))
    else $error("oversize rotate not flagged");
  chk_err_pulse:
  assert property (proc_err_o |-> done_o)
    else $error("error pulse without completion");
endmodule

bind sce_exec sce_exec_chk u_chk (
  .clk_i, .rst_i, .start_i, .instr_i, .busy_o, .done_o,
  .ind_gt_o, .ind_lt_o, .ind_eq_o, .proc_err_o
);

/* File: verification/sce_seq_model.sv */
// far-side model: instruction sequencer and operand fetch.
// assumes the bench asks for one instruction at a time on req_i.
`timescale 1ns/1ps

module sce_seq_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        busy_i,
  input  wire logic [24:0] instr_d_i,
  input  wire logic [24:0] hi_d_i,
  input  wire logic [24:0] lo_d_i,
  input  wire logic [24:0] fm_d_i,
  output logic             start_o,
  output logic [24:0]      instr_o,
  output logic [24:0]      mem_hi_o,
  output logic [24:0]      mem_lo_o,
  output logic [24:0]      field_mask_o
);
  logic        pend_reg;
  logic [99:0] hold_reg;
  // ==========================================
  // issue; the count field is handed over already resolved
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
      start_o  <= 1'b0;
      {instr_o, mem_hi_o, mem_lo_o, field_mask_o} <= '0;
    end else if (pend_reg && !busy_i && !start_o) begin
      pend_reg <= 1'b0;
      start_o  <= 1'b1;
      {instr_o, mem_hi_o, mem_lo_o, field_mask_o} <= hold_reg;
    end else begin
      pend_reg <= pend_reg | req_i;
      start_o  <= 1'b0;
      // operands are stale outside the start cycle, so never leave them steady
      {instr_o, mem_hi_o, mem_lo_o, field_mask_o} <= ~{instr_o, mem_hi_o, mem_lo_o, field_mask_o};
    end
  end

  always_ff @(posedge clk_i) begin
    if (req_i) begin
      hold_reg <= {instr_d_i, hi_d_i, lo_d_i, fm_d_i};
    end
  end
endmodule

/* File: verification/shift_compare_execution_unit_tb_top.sv */
// self-checking bench: random instructions against a reference model.
// assumes the sequencer model on the operand side, registers over wishbone.
`timescale 1ns/1ps
`include "sce_consts.svh"

module shift_compare_execution_unit_tb_top;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, req = 0;
  logic [4:0]  adr = '0;
  logic [3:0]  sel = '0, msk;
  logic [31:0] dat = '0, rd_w, wb_dat_o;
  logic [24:0] di = '0, dh = '0, dl = '0, dm = '0, ins, r [4];
  logic [24:0] instr_i, mem_hi_i, mem_lo_i, field_mask_i;
  logic        wb_ack_o, start_i, busy_o, done_o, ig, il, ie, pe, es, ex;
  logic        st = 1'b0;
  logic [2:0]  ind = '0;
  logic [5:0]  op;
  logic [5:0]  ops [9] = '{`SCE_OP_BSH, `SCE_OP_DSR, `SCE_OP_DSL, `SCE_OP_CSR,
                           `SCE_OP_CSL, `SCE_OP_ROT, `SCE_OP_CMPA, `SCE_OP_CMPM, 6'h3f};
  logic [3:0]  bshm [7] = '{4'hc, 4'ha, 4'h9, 4'h6, 4'h5, 4'h3, `SCE_MULTI};
  int          n_mismatch = 0, cmp_count = 0, seed = 32'hcfd5, k, j;

  sce_exec uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .start_i(start_i), .instr_i(instr_i), .mem_hi_i(mem_hi_i),
    .mem_lo_i(mem_lo_i), .field_mask_i(field_mask_i), .busy_o(busy_o), .done_o(done_o),
    .ind_gt_o(ig), .ind_lt_o(il), .ind_eq_o(ie), .proc_err_o(pe));
  sce_seq_model u_seq (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .busy_i(busy_o),
    .instr_d_i(di), .hi_d_i(dh), .lo_d_i(dl), .fm_d_i(dm), .start_o(start_i),
    .instr_o(instr_i), .mem_hi_o(mem_hi_i), .mem_lo_o(mem_lo_i), .field_mask_o(field_mask_i));

  initial forever #25 clk_i = ~clk_i;
  // ==========================================
  // shared tasks
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_w = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic ref_op(input logic [24:0] i, h, l, m);
    int a, b, c, w, n, q;
    logic [47:0] d, x, y, f;
    logic [24:0] p;
    logic sr, sm;
    longint va, vb;
    a = -1;
    b = -1;
    c = i[9:0];
    ex = 0;
    for (q = 0; q < 4; q++)
      if (i[13 - q]) begin
        if (a < 0) a = q;
        else if (b < 0) b = q;
      end
    case (i[19:14])
      `SCE_OP_DSR, `SCE_OP_DSL, `SCE_OP_CSR, `SCE_OP_CSL: begin
        w = i[15] ? 6 : 4;
        f = i[15] ? 0 : 3;
        n = b < 0 ? 24 : 48;
        d = b < 0 ? 48'(r[a][23:0]) : {r[a][23:0], r[b][23:0]};
        ex = c > n / w;
        for (q = 0; q < c && q < n / w; q++)
          d = i[14] ? (d << w | f) & ((48'h1 << n) - 1) : d >> w | f << (n - w);
        if (b < 0) r[a][23:0] = d[23:0];
        else {r[a][23:0], r[b][23:0]} = d;
      end
      `SCE_OP_ROT: begin
        ex = c > 25;
        repeat (c % 25) r[a] = {r[a][0], r[a][24:1]};
      end
      `SCE_OP_CMPA, `SCE_OP_CMPM: begin
        p = i[24] ? m : '1;
        x = b < 0 ? 48'(r[a][23:0] & p[23:0]) : {r[a][23:0] & p[23:0], r[b][23:0] & p[23:0]};
        y = b < 0 ? 48'(l[23:0] & p[23:0]) : {h[23:0] & p[23:0], l[23:0] & p[23:0]};
        sr = r[b < 0 ? a : b][24] & p[24];
        sm = l[24] & p[24];
        ind = x > y ? 3'h4 : x < y ? 3'h2 : 3'h1;
        if (!i[14]) begin
          if (sr != sm) ind = sr ? 3'h2 : 3'h4;
          else if (sr && ind != 3'h1) ind = ind ^ 3'h6;
        end
      end
      `SCE_OP_BSH: if (b >= 0) begin
        // multiword: 12 is the minuend with the low word's sign, 3 takes the result
        sm = i[13:10] == `SCE_MULTI;
        x = sm ? {r[0][23:0], r[1][23:0]} : 48'(r[a][23:0]);
        y = sm ? {h[23:0], l[23:0]} : 48'(l[23:0]);
        sr = sm ? r[1][24] : r[a][24];
        va = sr ? -longint'(x) : longint'(x);
        vb = l[24] ? -longint'(y) : longint'(y);
        va = va - vb;
        d = 48'(va < 0 ? -va : va);
        // a zero difference keeps the minuend's sign
        sr = va < 0 || (va == 0 && sr);
        if (sm) {r[2], r[3]} = {sr, d[47:24], sr, d[23:0]};
        else r[b] = {sr, d[23:0]};
      end
      default: ;
    endcase
  endtask

  task automatic run(input logic [24:0] i, h, l, m);
    @(posedge clk_i);
    req <= 1'b1;
    di  <= i;
    dh  <= h;
    dl  <= l;
    dm  <= m;
    @(posedge clk_i);
    req <= 1'b0;
    do @(posedge clk_i); while (busy_o !== 1'b1);
    // a taken compare clears all indicators; other codes leave them standing
    chk_w("indicator", (i[19:15] == 5'h16) ? 32'h0 : 32'(ind), 32'({ig, il, ie}));
    do @(posedge clk_i); while (done_o !== 1'b1);
    es = pe;
    ref_op(i, h, l, m);
    chk_w("error", 32'(ex), 32'(es));
    chk_w("indicator", 32'(ind), 32'({ig, il, ie}));
    st = st | ex;
    for (int q = 0; q < 4; q++) begin
      wb(1'b0, 5'(q * 4), '0);
      chk_w("register", {7'h0, r[q]}, rd_w);
    end
    wb(1'b0, `SCE_ADR_STAT, '0);
    chk_w("status", {27'h0, ind[0], ind[1], ind[2], st, 1'b0}, rd_w);
    if (st) begin
      // sticky error is cleared by writing one to it
      wb(1'b1, `SCE_ADR_STAT, 32'h2);
      st = 1'b0;
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 6; k++) begin
      wb(1'b0, 5'(k * 4), '0);
      chk_w("reset read", '0, rd_w);
    end
    for (j = 0; j < 150; j++) begin
      for (k = 0; k < 4; k++) begin
        r[k] = 25'($random(seed));
        wb(1'b1, 5'(k * 4), {7'h0, r[k]});
      end
      op = ops[{$random(seed)} % 9];
      msk = 4'($random(seed));
      if (msk == 4'h0) msk = 4'h1;
      if (op == `SCE_OP_BSH) msk = bshm[{$random(seed)} % 7];
      k = op == `SCE_OP_ROT ? {$random(seed)} % 31 : {$random(seed)} % 16;
      ins = {1'($random(seed)), 4'($random(seed)), op, msk, 10'(k)};
      run(ins, 25'($random(seed)), 25'($random(seed)), 25'($random(seed)));
    end
    r[3] = '0;
    wb(1'b1, 5'h0c, '0);
    run({5'h0, `SCE_OP_CMPA, 4'h1, 10'h0}, '0, 25'h1000000, '0);
    final_report;
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    final_report;
  end
endmodule
